/* File: inc/tone_pkg.sv */
// constants, register map and state types for the tone and fsk transmitter
// assumes a 250 MHz core clock and a 32-bit ahb-lite register bus
package tone_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LATCH_HZ = 1200;
  localparam int unsigned LATCH_DIV = CLK_HZ / LATCH_HZ;
  localparam int unsigned TONE_DIV_W = 20;
  localparam logic [11:0] OFS_TONE_CTRL = 12'h0ba;
  localparam logic [11:0] OFS_FSK_BIT = 12'h0c0;
  localparam logic [11:0] OFS_FSK_CTRL = 12'h0c4;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h0c8;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h0cc;
  localparam logic [11:0] OFS_IRQ_EN = 12'h0d0;
  localparam int unsigned POS_PIN_EN = 6;
  localparam int unsigned POS_HIGH_EN = 5;
  localparam int unsigned POS_LOW_EN = 4;
  localparam int unsigned POS_LOW_SEL = 2;
  localparam int unsigned POS_HIGH_SEL = 0;
  localparam int unsigned POS_TX_EN = 0;
  localparam int unsigned POS_SEND = 1;
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam int unsigned FSK_MARK_HZ = 1300;
  localparam int unsigned FSK_SPACE_HZ = 2100;

  typedef struct packed {
    logic [31:0] haddr;
    logic hwrite;
    logic hsel_ok;
  } bus_req_t;

  typedef struct packed {
    bus_req_t req;
    logic [7:0] tone_ctrl;
    logic [7:0] fsk_bit;
    logic tx_en;
    logic send;
    logic mod_flag;
    logic irq_en;
    logic latched_bit;
    logic [17:0] latch_cnt;
    logic [TONE_DIV_W-1:0] low_cnt;
    logic [TONE_DIV_W-1:0] high_cnt;
    logic [TONE_DIV_W-1:0] fsk_cnt;
    logic low_sq;
    logic high_sq;
    logic fsk_sq;
    logic [31:0] hrdata;
  } tone_state_t;
endpackage : tone_pkg

/* File: rtl/tone_gen.sv */
// dtmf tone and 1200 baud fsk transmitter with ahb-lite registers
// assumes a single ahb-lite master and an outside buffer on the tone pin
//
// Overview of operation
// - tone pin carries one low group tone and one high group tone
// - tone pin released when the dual tone path and the fsk modulator are both off
// - tone control register at BAh with enables and two selectors
// - each group tone runs only while its group enable is set
// - dual tone reaches the pin only with the pin enable set
// - high selector 00 gives 1209 Hz, 01 gives 1336 Hz
// - fsk modulator and dual tone share the one tone pin
// - fsk sends 1200 baud, mark and space tones
// - only bit 0 of the transmit bit register is sent
// - setting transmit enable raises send flag, starting 1200 Hz clock
// - while send is high, bit 0 is latched at each latch edge
// - after send clears, next latch edge drops enable
// - while enabled, each latch edge sets the modulation flag
// - modulation flag raises the shared cid interrupt
// - clearing transmit enable stops fsk output at once
`timescale 1ns/1ns
module tone_gen
  import tone_pkg::*;
#(
  // latch period in core clocks; shorten only for simulation
  parameter int unsigned LATCH_CYC = LATCH_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // tone pin
  output logic tone_out,
  output logic tone_oe,
  // interrupt
  output logic cid_irq
);
  logic rst_s1_ff;
  logic rst_s2_ff;
  tone_state_t st_ff;
  tone_state_t nxt_st;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // half period of a square tone in core clocks
  function automatic logic [TONE_DIV_W-1:0] half_div(input int unsigned hz);
    half_div = TONE_DIV_W'(CLK_HZ / (2 * hz));
  endfunction : half_div

  // one register per word; the offset constants are word indices
  function automatic logic [11:0] reg_idx(input logic [31:0] a);
    reg_idx = a[13:2];
  endfunction : reg_idx

  function automatic logic [TONE_DIV_W-1:0] low_div(input logic [1:0] s);
    unique case (s)
      2'b00: low_div = half_div(697);
      2'b01: low_div = half_div(770);
      2'b10: low_div = half_div(852);
      2'b11: low_div = half_div(941);
    endcase
  endfunction : low_div

  function automatic logic [TONE_DIV_W-1:0] high_div(input logic [1:0] s);
    unique case (s)
      2'b00: high_div = half_div(1209);
      2'b01: high_div = half_div(1336);
      2'b10: high_div = half_div(1477);
      2'b11: high_div = half_div(1633);
    endcase
  endfunction : high_div

  logic wr_go;
  logic rd_go;
  logic addr_ph;
  logic latch_edge;
  logic [11:0] wr_idx;
  logic [31:0] wdata;
  logic [7:0] irq_stat;
  logic [TONE_DIV_W-1:0] lo_lim;
  logic [TONE_DIV_W-1:0] hi_lim;
  logic [TONE_DIV_W-1:0] fsk_lim;

  assign addr_ph = hsel && hready && htrans[1];
  assign wr_go = st_ff.req.hsel_ok && st_ff.req.hwrite;
  assign wdata = hwdata;
  assign latch_edge = st_ff.latch_cnt == 18'(LATCH_CYC - 1);
  assign wr_idx = reg_idx(st_ff.req.haddr);
  assign irq_stat = {7'h00, st_ff.mod_flag};
  assign lo_lim = low_div(st_ff.tone_ctrl[POS_LOW_SEL +: 2]);
  assign hi_lim = high_div(st_ff.tone_ctrl[POS_HIGH_SEL +: 2]);
  assign fsk_lim = st_ff.latched_bit ? half_div(FSK_MARK_HZ)
                                     : half_div(FSK_SPACE_HZ);
  assign rd_go = addr_ph && !hwrite;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.req.haddr = haddr;
    nxt_st.req.hwrite = hwrite;
    nxt_st.req.hsel_ok = addr_ph;
    // read data registered in the address phase, so zero wait states
    if (rd_go) begin
      unique case (reg_idx(haddr))
        OFS_TONE_CTRL: nxt_st.hrdata = {24'h0, 1'b0, st_ff.tone_ctrl[6:0]};
        OFS_FSK_BIT: nxt_st.hrdata = {24'h0, st_ff.fsk_bit};
        OFS_FSK_CTRL: nxt_st.hrdata = {30'h0, st_ff.send, st_ff.tx_en};
        OFS_IRQ_STAT: nxt_st.hrdata = {24'h0, irq_stat};
        OFS_IRQ_EN: nxt_st.hrdata = {31'h0, st_ff.irq_en};
        default: nxt_st.hrdata = 32'h0;
      endcase
    end
    // latch clock starts with send and runs on to the closing edge
    if (st_ff.tx_en) begin
      nxt_st.latch_cnt = latch_edge ? 18'h0 : st_ff.latch_cnt + 18'h1;
    end else begin
      nxt_st.latch_cnt = 18'h0;
    end
    if (st_ff.tx_en && latch_edge) begin
      nxt_st.mod_flag = 1'b1;
    end
    if (st_ff.send && latch_edge) begin
      nxt_st.latched_bit = st_ff.fsk_bit[0];
    end
    // send dropped by software: end transmission at the next latch edge
    if (st_ff.tx_en && !st_ff.send && latch_edge) begin
      nxt_st.tx_en = 1'b0;
    end
    if (wr_go) begin
      unique case (wr_idx)
        OFS_TONE_CTRL: nxt_st.tone_ctrl = {1'b0, wdata[6:0]};
        OFS_FSK_BIT: nxt_st.fsk_bit = wdata[7:0];
        OFS_FSK_CTRL: begin
          if (wdata[POS_TX_EN] && !st_ff.tx_en) begin
            nxt_st.tx_en = 1'b1;
            nxt_st.send = 1'b1;
          end else if (!wdata[POS_TX_EN]) begin
            nxt_st.tx_en = 1'b0;
            nxt_st.send = 1'b0;
          end else if (!wdata[POS_SEND]) begin
            nxt_st.send = 1'b0;
          end
        end
        // set wins over clear on the same edge
        OFS_IRQ_CLR: begin
          if (wdata[0] && !(st_ff.tx_en && latch_edge)) begin
            nxt_st.mod_flag = 1'b0;
          end
        end
        OFS_IRQ_EN: nxt_st.irq_en = wdata[0];
        default: begin
        end
      endcase
    end
    // tone dividers stop and reset while their enable is low
    if (st_ff.tone_ctrl[POS_LOW_EN]) begin
      if (st_ff.low_cnt >= lo_lim - TONE_DIV_W'(1)) begin
        nxt_st.low_cnt = '0;
        nxt_st.low_sq = !st_ff.low_sq;
      end else begin
        nxt_st.low_cnt = st_ff.low_cnt + TONE_DIV_W'(1);
      end
    end else begin
      nxt_st.low_cnt = '0;
      nxt_st.low_sq = 1'b0;
    end
    if (st_ff.tone_ctrl[POS_HIGH_EN]) begin
      if (st_ff.high_cnt >= hi_lim - TONE_DIV_W'(1)) begin
        nxt_st.high_cnt = '0;
        nxt_st.high_sq = !st_ff.high_sq;
      end else begin
        nxt_st.high_cnt = st_ff.high_cnt + TONE_DIV_W'(1);
      end
    end else begin
      nxt_st.high_cnt = '0;
      nxt_st.high_sq = 1'b0;
    end
    if (st_ff.tx_en) begin
      if (st_ff.fsk_cnt >= fsk_lim - TONE_DIV_W'(1)) begin
        nxt_st.fsk_cnt = '0;
        nxt_st.fsk_sq = !st_ff.fsk_sq;
      end else begin
        nxt_st.fsk_cnt = st_ff.fsk_cnt + TONE_DIV_W'(1);
      end
    end else begin
      nxt_st.fsk_cnt = '0;
      nxt_st.fsk_sq = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // one bit pin model: xor mixes the two squares into one waveform
  always_comb begin
    tone_out = 1'b0;
    tone_oe = 1'b0;
    if (st_ff.tx_en) begin
      tone_out = st_ff.fsk_sq;
      tone_oe = 1'b1;
    end else if (st_ff.tone_ctrl[POS_PIN_EN]) begin
      tone_out = st_ff.low_sq ^ st_ff.high_sq;
      tone_oe = 1'b1;
    end
  end

  assign cid_irq = st_ff.mod_flag && st_ff.irq_en;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.hrdata;

  property p_pin_off;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (!st_ff.tx_en && !st_ff.tone_ctrl[POS_PIN_EN]) |-> !tone_oe;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven");

  property p_low_quiet;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      !st_ff.tone_ctrl[POS_LOW_EN] |=> !st_ff.low_sq;
  endproperty
  a_low_quiet: assert property (p_low_quiet) else $error("low on");

  property p_start;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (wr_go && wr_idx == OFS_FSK_CTRL && wdata[0]
       && !st_ff.tx_en) |=> (st_ff.tx_en && st_ff.send);
  endproperty
  a_start: assert property (p_start) else $error("no start");

  property p_flag;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (st_ff.tx_en && latch_edge) |=> st_ff.mod_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag miss");

  property p_flag_hold;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (st_ff.mod_flag && !(wr_go && wr_idx == OFS_IRQ_CLR))
      |=> st_ff.mod_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_irq;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      cid_irq == (st_ff.mod_flag && st_ff.irq_en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");

  property p_stop;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (wr_go && wr_idx == OFS_FSK_CTRL && !wdata[0])
      |=> (!st_ff.tx_en && !(tone_oe && !st_ff.tone_ctrl[POS_PIN_EN]));
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");

  property p_latch;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (st_ff.send && latch_edge)
      |=> st_ff.latched_bit == $past(st_ff.fsk_bit[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("bit miss");

  // closing latch edge after send was dropped
  sequence s_last_edge;
    st_ff.tx_en && !st_ff.send && latch_edge;
  endsequence

  sequence s_tx_idle;
    !st_ff.tx_en && !st_ff.send;
  endsequence

  property p_end;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      s_last_edge |=> s_tx_idle;
  endproperty
  a_end: assert property (p_end) else $error("no end");

  // the bit in flight finishes before the modulator stops
  property p_drain;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (st_ff.tx_en && !st_ff.send && !latch_edge
       && !(wr_go && wr_idx == OFS_FSK_CTRL)) |=> st_ff.tx_en;
  endproperty
  a_drain: assert property (p_drain) else $error("early end");

  property p_hi_quiet;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      !st_ff.tone_ctrl[POS_HIGH_EN] |=> !st_ff.high_sq;
  endproperty
  a_hi_quiet: assert property (p_hi_quiet) else $error("high on");

  property p_mix;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (!st_ff.tx_en && st_ff.tone_ctrl[POS_PIN_EN])
      |-> (tone_oe && tone_out == (st_ff.low_sq ^ st_ff.high_sq));
  endproperty
  a_mix: assert property (p_mix) else $error("pin mix");

  // fsk owns the pin while it transmits
  property p_fsk_pin;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      st_ff.tx_en |-> (tone_oe && tone_out == st_ff.fsk_sq);
  endproperty
  a_fsk_pin: assert property (p_fsk_pin) else $error("pin fsk");

  property p_bit7;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      !st_ff.tone_ctrl[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 set");

  // half periods of the first two column tones
  property p_col1;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (st_ff.tone_ctrl[POS_HIGH_SEL +: 2] == 2'b00)
      |-> (hi_lim == TONE_DIV_W'(CLK_HZ / (2 * 1209)));
  endproperty
  a_col1: assert property (p_col1) else $error("col 1 rate");

  property p_col2;
    @(posedge core_clk) disable iff (!rst_s2_ff)
      (st_ff.tone_ctrl[POS_HIGH_SEL +: 2] == 2'b01)
      |-> (hi_lim == TONE_DIV_W'(CLK_HZ / (2 * 1336)));
  endproperty
  a_col2: assert property (p_col2) else $error("col 2 rate");
endmodule : tone_gen

/* File: verif/line_model.sv */
// far side of the shared tone pin: the analog line
// assumes no pull resistor on the pin, so an undriven line floats
`timescale 1ns/1ns
module line_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // shared tone pin
  input wire logic tone_out,
  input wire logic tone_oe,
  // observed line
  output logic line_lvl,
  output logic [31:0] edge_cnt
);
  logic last_ff;
  // floating line shows the inverse, so a held value cannot pass
  assign line_lvl = tone_oe ? tone_out : ~last_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_ff <= 1'b0;
      edge_cnt <= 32'h0;
    end else if (tone_oe) begin
      last_ff <= tone_out;
      if (tone_out != last_ff) begin
        edge_cnt <= edge_cnt + 32'h1;
      end
    end
  end
endmodule : line_model

/* File: verif/tone_gen_tb_top.sv */
// self-checking bench for the tone and fsk transmitter
// assumes no wait count of the slave; latch period shortened for the run
`timescale 1ns/1ns
module tone_gen_tb_top;
  import tone_pkg::*;
  // a full latch period would overrun the cycle budget of the run
  localparam int unsigned TB_LATCH = 2000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, tone_out, tone_oe, cid_irq, line_lvl;
  logic [31:0] hrdata, edge_cnt, rd, e0;
  int err_count = 0;
  int checks = 0;
  int n;

  always #2 core_clk = ~core_clk;

  tone_gen #(.LATCH_CYC(TB_LATCH)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tone_out(tone_out), .tone_oe(tone_oe),
    .cid_irq(cid_irq));

  line_model line (.core_clk(core_clk), .rst_n(rst_n),
    .tone_out(tone_out), .tone_oe(tone_oe), .line_lvl(line_lvl),
    .edge_cnt(edge_cnt));

  task stop_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // no cycle count is assumed of the slave; hreadyout or the bound ends a wait
  task wait_rdy;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask : wait_rdy

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr <= {18'h0, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rchk

  task oe_chk(input logic exp);
    @(posedge core_clk);
    chk({31'h0, tone_oe}, {31'h0, exp});
  endtask : oe_chk

  // bound is one latch period and some slack
  task wait_irq;
    n = 0;
    while (cid_irq !== 1'b1 && n < TB_LATCH + 100) begin
      @(posedge core_clk);
      n++;
    end
    if (cid_irq !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask : wait_irq

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({31'h0, tone_oe}, 32'h0);
    rchk(OFS_TONE_CTRL, {24'h0, RST_REG8});
    rchk(OFS_FSK_CTRL, 32'h0);
    rchk(OFS_IRQ_STAT, 32'h0);
    rchk(12'h0f0, 32'h0);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, OFS_TONE_CTRL, 32'h70 | i);
      rchk(OFS_TONE_CTRL, 32'h70 | i);
      chk({31'h0, tone_oe}, 32'h1);
    end
    xfer(1'b1, OFS_TONE_CTRL, 32'h30);
    oe_chk(1'b0);
    // pin driven but both groups off: the line must stay quiet
    xfer(1'b1, OFS_TONE_CTRL, 32'h40);
    oe_chk(1'b1);
    chk({31'h0, line_lvl}, 32'h0);
    e0 = edge_cnt;
    repeat (1000) @(posedge core_clk);
    chk(edge_cnt, e0);
    xfer(1'b1, OFS_TONE_CTRL, 32'h0);
    xfer(1'b1, OFS_IRQ_EN, 32'h1);
    xfer(1'b1, OFS_FSK_BIT, 32'hfe);
    rchk(OFS_FSK_BIT, 32'hfe);
    xfer(1'b1, OFS_FSK_CTRL, 32'h1);
    wait_irq();
    chk({31'h0, n >= TB_LATCH - 4 && n <= TB_LATCH + 4}, 32'h1);
    chk({31'h0, tone_oe}, 32'h1);
    rchk(OFS_FSK_CTRL, 32'h3);
    rchk(OFS_IRQ_STAT, 32'h1);
    xfer(1'b1, OFS_IRQ_EN, 32'h0);
    @(posedge core_clk);
    chk({31'h0, cid_irq}, 32'h0);
    rchk(OFS_IRQ_STAT, 32'h1);
    xfer(1'b1, OFS_IRQ_EN, 32'h1);
    @(posedge core_clk);
    chk({31'h0, cid_irq}, 32'h1);
    xfer(1'b1, OFS_IRQ_CLR, 32'h1);
    rchk(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, cid_irq}, 32'h0);
    xfer(1'b1, OFS_FSK_CTRL, 32'h1);
    rchk(OFS_FSK_CTRL, 32'h1);
    chk({31'h0, tone_oe}, 32'h1);
    wait_irq();
    rchk(OFS_FSK_CTRL, 32'h0);
    oe_chk(1'b0);
    xfer(1'b1, OFS_IRQ_CLR, 32'h1);
    xfer(1'b1, OFS_FSK_CTRL, 32'h1);
    oe_chk(1'b1);
    xfer(1'b1, OFS_FSK_CTRL, 32'h0);
    oe_chk(1'b0);
    rchk(OFS_FSK_CTRL, 32'h0);
    stop_test();
  end
endmodule : tone_gen_tb_top
